/* File: src/cfo_pkg.sv */
// Constants, register map and carrier types of the CAN filter, timing and output block.
// Assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
//
// Summary of operation
// - Config registers accessible only during reset request.
// - Accepted message stored in order into empty buffer.
// - No empty buffer for accepted message sets overrun.
// - Completed message sets buffer full; receive flag only with CTL_RX_IE set.
// - Accept when each identifier bit matches or masked.
// - Own transmitted messages are filtered and stored too.
// - Quantum equals two clocks times prescaler plus one.
// - Resynchronize on relevant bus edges.
// - One resync shifts bit by at most jump width.
// - Triple sampling uses majority, otherwise sample once.
// - Segment lengths are quanta times field plus one.
// - Sleep drives recessive level on both outputs.
// - Reset request leaves both output drivers floating.
// - Normal mode sends bit stream on both pins.
// - Clock mode puts bit-start clock on second pin.
// - Bi-phase floats both outputs on recessive bits.
// - Bi-phase alternates dominant bits, first pin first.
// - Test mode feeds comparator to second driver.
// - Mode codes: 10 normal, 11 clock, 00 biphase, 01 test.
// - Pull-up, pull-down, polarity select pin drive.
package cfo_pkg;

	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index.
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_CONTROL = 6'h00;
	localparam logic [5:0] IDX_COMMAND = 6'h01;
	localparam logic [5:0] IDX_STATUS = 6'h02;
	localparam logic [5:0] IDX_FILTER_CODE = 6'h04;
	localparam logic [5:0] IDX_FILTER_MASK = 6'h05;
	localparam logic [5:0] IDX_BT_PRESCALE = 6'h06;
	localparam logic [5:0] IDX_BT_SEGMENTS = 6'h07;
	localparam logic [5:0] IDX_OUTPUT_CTRL = 6'h08;
	localparam logic [5:0] IDX_RXBUF_BASE = 6'h14;
	localparam logic [3:0] RXBUF_BYTES = 4'ha;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int CTL_RESET_REQ = 0;
	localparam int CTL_SLEEP = 1;
	localparam int CTL_RX_IE = 2;
	localparam int CMD_RELEASE = 0;
	localparam int CMD_CLR_OVERRUN = 1;
	localparam int CMD_CLR_RX_FLAG = 2;
	localparam int STA_RX_FULL = 0;
	localparam int STA_OVERRUN = 1;
	localparam int STA_RX_FLAG = 2;
	localparam int STA_SAMPLED = 3;

	// ----------------------------------------------------------------
	// Reset values.
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL = 8'h01;
	localparam logic [7:0] RST_CONFIG = 8'h00;

	// ----------------------------------------------------------------
	// Output modes and AXI responses.
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_BIPHASE = 2'h0;
	localparam logic [1:0] MODE_TEST = 2'h1;
	localparam logic [1:0] MODE_NORMAL = 2'h2;
	localparam logic [1:0] MODE_CLOCK = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum {SEG_SYNC, SEG_ONE, SEG_TWO} cfo_seg_t;

	typedef struct packed {
		logic [1:0] jump_width;
		logic [5:0] quantum_prescaler;
	} cfo_prescale_t;

	typedef struct packed {
		logic triple_sample_select;
		logic [2:0] segment_two_length;
		logic [3:0] segment_one_length;
	} cfo_segments_t;

	typedef struct packed {
		logic pullup_enable;
		logic pulldown_enable;
		logic output_polarity;
	} cfo_pin_cfg_t;

	typedef struct packed {
		cfo_pin_cfg_t pin_b;
		cfo_pin_cfg_t pin_a;
		logic output_mode_hi;
		logic output_mode_lo;
	} cfo_output_t;

	typedef struct packed {
		logic out;
		logic oe;
	} cfo_drive_t;

endpackage

/* File: src/cfo_filter_timing.sv */
// CAN acceptance filter, receive storage, bit timing and output stage with AXI4-Lite registers.
// Assumes a frame engine that supplies identifier, data bytes and the transmit bit stream.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cfo_filter_timing
	import cfo_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic msg_start,
	input wire logic [7:0] msg_id_high,
	input wire logic msg_byte_valid,
	input wire logic [7:0] msg_byte,
	input wire logic msg_done,
	input wire logic msg_abort,
	input wire logic tx_bit,
	input wire logic comp_in,
	output logic sample_strobe,
	output logic sampled_bit,
	output logic bit_start,
	output logic serial_out_a,
	output logic serial_out_a_oe,
	output logic serial_out_b,
	output logic serial_out_b_oe
);

	// ----------------------------------------------------------------
	// Functions.
	// ----------------------------------------------------------------
	function automatic logic [5:0] reg_index(input logic [7:0] addr);
		reg_index = addr[7:2];
	endfunction

	function automatic logic is_config(input logic [5:0] idx);
		is_config = (idx >= IDX_FILTER_CODE) && (idx <= IDX_OUTPUT_CTRL);
	endfunction

	function automatic cfo_drive_t pin_drive(input cfo_pin_cfg_t c, input logic d);
		logic lvl;
		lvl = d ^ c.output_polarity;
		pin_drive.out = c.pullup_enable & lvl;
		pin_drive.oe = (c.pullup_enable & lvl) | (c.pulldown_enable & ~lvl);
	endfunction

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	logic [7:0] control_reg;
	logic [7:0] filter_code_reg;
	logic [7:0] filter_mask_reg;
	cfo_prescale_t prescale_reg;
	cfo_segments_t segments_reg;
	cfo_output_t output_reg;
	logic overrun_reg;
	logic rx_flag_reg;
	logic [1:0] buf_full_reg;
	logic rd_sel_reg;
	logic wr_sel_reg;
	logic storing_reg;
	logic [3:0] wr_ptr_reg;
	logic [7:0] rxmem [0:1][0:9];
	logic [7:0] aw_idx_reg;
	logic aw_held_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic w_held_reg;

	wire reset_req = control_reg[CTL_RESET_REQ];
	wire sleep_mode = control_reg[CTL_SLEEP];

	// ----------------------------------------------------------------
	// AXI4-Lite write channel.
	// ----------------------------------------------------------------
	wire [5:0] wr_idx = reg_index(aw_idx_reg);
	wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire wr_mapped = (wr_idx <= IDX_STATUS) || is_config(wr_idx);
	wire wr_refused = is_config(wr_idx) && !reset_req;
	wire wr_do = wr_fire && wr_mapped && !wr_refused && wstrb_reg[0];
	wire [7:0] wr_byte = wdata_reg[7:0];
	wire cmd_write = wr_do && (wr_idx == IDX_COMMAND);
	wire cmd_release = cmd_write && wr_byte[CMD_RELEASE];
	wire cmd_clr_ovr = cmd_write && wr_byte[CMD_CLR_OVERRUN];
	wire cmd_clr_flag = cmd_write && wr_byte[CMD_CLR_RX_FLAG];

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_idx_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= !wr_mapped ? RESP_DECERR : (wr_refused ? RESP_SLVERR : RESP_OKAY);
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_reg <= RST_CONTROL;
			filter_code_reg <= RST_CONFIG;
			filter_mask_reg <= RST_CONFIG;
			prescale_reg <= RST_CONFIG;
			segments_reg <= RST_CONFIG;
			output_reg <= RST_CONFIG;
		end else if (wr_do) begin
			case (wr_idx)
				IDX_CONTROL: control_reg <= wr_byte;
				IDX_FILTER_CODE: filter_code_reg <= wr_byte;
				IDX_FILTER_MASK: filter_mask_reg <= wr_byte;
				IDX_BT_PRESCALE: prescale_reg <= wr_byte;
				IDX_BT_SEGMENTS: segments_reg <= wr_byte;
				IDX_OUTPUT_CTRL: output_reg <= wr_byte;
				default: control_reg <= control_reg;
			endcase
		end
	end

	a_cfg_write_locked: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && is_config(wr_idx) && !reset_req) |=> $stable(filter_code_reg)
		&& $stable(output_reg) && s_axi_bresp == RESP_SLVERR)
		else $error("Config register changed outside reset request.");

	// ----------------------------------------------------------------
	// AXI4-Lite read channel.
	// ----------------------------------------------------------------
	wire [5:0] rd_idx = reg_index(s_axi_araddr);
	wire [5:0] rd_off = rd_idx - IDX_RXBUF_BASE;
	wire rd_in_buf = (rd_idx >= IDX_RXBUF_BASE) && (rd_off < {2'b00, RXBUF_BYTES});
	wire rd_refused = is_config(rd_idx) && !reset_req;
	wire [7:0] status_byte = {4'h0, sampled_bit, rx_flag_reg, overrun_reg, |buf_full_reg};
	logic [7:0] rd_byte;
	logic rd_mapped;

	always_comb begin
		rd_mapped = 1'b1;
		rd_byte = 8'h00;
		case (rd_idx)
			IDX_CONTROL: rd_byte = control_reg;
			IDX_COMMAND: rd_byte = 8'h00;
			IDX_STATUS: rd_byte = status_byte;
			IDX_FILTER_CODE: rd_byte = filter_code_reg;
			IDX_FILTER_MASK: rd_byte = filter_mask_reg;
			IDX_BT_PRESCALE: rd_byte = prescale_reg;
			IDX_BT_SEGMENTS: rd_byte = segments_reg;
			IDX_OUTPUT_CTRL: rd_byte = output_reg;
			default: begin
				rd_mapped = rd_in_buf;
				rd_byte = rd_in_buf ? rxmem[rd_sel_reg][rd_off[3:0]] : 8'h00;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= (rd_refused || !rd_mapped) ? 32'h0000_0000 : {24'h000000, rd_byte};
			s_axi_rresp <= !rd_mapped ? RESP_DECERR : (rd_refused ? RESP_SLVERR : RESP_OKAY);
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Acceptance filter and receive storage.
	// ----------------------------------------------------------------
	wire accept = &((msg_id_high ~^ filter_code_reg) | filter_mask_reg);
	wire free_a = !buf_full_reg[0];
	wire free_b = !buf_full_reg[1];
	wire start_ok = msg_start && accept && (free_a || free_b);
	wire start_ovr = msg_start && accept && !free_a && !free_b;
	wire store_byte = storing_reg && msg_byte_valid && (wr_ptr_reg < RXBUF_BYTES);
	wire store_done = storing_reg && msg_done;
	wire [1:0] fill_set = store_done ? (2'b01 << wr_sel_reg) : 2'b00;
	wire [1:0] fill_clr = cmd_release ? (2'b01 << rd_sel_reg) : 2'b00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			storing_reg <= 1'b0;
			wr_sel_reg <= 1'b0;
			wr_ptr_reg <= 4'h0;
			buf_full_reg <= 2'b00;
			rd_sel_reg <= 1'b0;
			overrun_reg <= 1'b0;
			rx_flag_reg <= 1'b0;
		end else begin
			if (start_ok) begin
				storing_reg <= 1'b1;
				wr_sel_reg <= free_a ? 1'b0 : 1'b1;
				wr_ptr_reg <= 4'h0;
			end else if (store_done || msg_abort) begin
				storing_reg <= 1'b0;
			end else if (store_byte) begin
				wr_ptr_reg <= wr_ptr_reg + 4'h1;
			end
			buf_full_reg <= fill_set | (buf_full_reg & ~fill_clr);
			if (cmd_release && buf_full_reg[rd_sel_reg]) begin
				rd_sel_reg <= !rd_sel_reg;
			end else if (!(|buf_full_reg) && store_done) begin
				rd_sel_reg <= wr_sel_reg;
			end
			overrun_reg <= start_ovr || (overrun_reg && !cmd_clr_ovr);
			rx_flag_reg <= (store_done && control_reg[CTL_RX_IE]) || (rx_flag_reg && !cmd_clr_flag);
		end
	end

	always_ff @(posedge aclk) begin
		if (store_byte) begin
			rxmem[wr_sel_reg][wr_ptr_reg] <= msg_byte;
		end
	end

	a_store_buffer: assert property (@(posedge aclk) disable iff (!aresetn)
		start_ok |=> storing_reg && !buf_full_reg[wr_sel_reg] && wr_ptr_reg == 4'h0)
		else $error("Accepted message not routed to an empty buffer.");
	a_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(msg_start && accept && buf_full_reg == 2'b11) |=> overrun_reg)
		else $error("Overrun not flagged with both buffers full.");
	a_full_on_done: assert property (@(posedge aclk) disable iff (!aresetn)
		(store_done && control_reg[CTL_RX_IE]) |=> (|buf_full_reg) && rx_flag_reg)
		else $error("Completed message did not set full and flag.");
	a_reject_filter: assert property (@(posedge aclk) disable iff (!aresetn)
		(msg_start && ((msg_id_high ^ filter_code_reg) & ~filter_mask_reg) != 8'h00
		&& !storing_reg) |=> !storing_reg && $stable(overrun_reg))
		else $error("Filtered message was accepted.");

	// ----------------------------------------------------------------
	// Quantum generator and bit timing.
	// ----------------------------------------------------------------
	logic [6:0] tq_cnt_reg;
	cfo_seg_t seg_reg;
	logic [4:0] q_cnt_reg;
	logic [2:0] ext_reg;
	logic [2:0] shr_reg;
	logic resynced_reg;
	logic comp_prev_reg;
	logic [1:0] hist_reg;

	wire [6:0] tq_limit = {prescale_reg.quantum_prescaler, 1'b1};
	wire tq_tick = (tq_cnt_reg == tq_limit);
	wire [2:0] sjw_len = {1'b0, prescale_reg.jump_width} + 3'h1;
	wire [4:0] seg1_len = {1'b0, segments_reg.segment_one_length} + 5'h1;
	wire [4:0] seg2_len = {2'b00, segments_reg.segment_two_length} + 5'h1;
	wire [4:0] q_next = q_cnt_reg + 5'h1;
	wire rx_edge = comp_prev_reg && !comp_in && !resynced_reg;
	wire [2:0] phase_err = (q_next > {2'b00, sjw_len}) ? sjw_len : q_next[2:0];
	wire seg1_end = tq_tick && (seg_reg == SEG_ONE) && (q_next >= seg1_len + {2'b00, ext_reg});
	wire seg2_end = tq_tick && (seg_reg == SEG_TWO) && (q_next + {2'b00, shr_reg} >= seg2_len);
	wire maj = (hist_reg[0] & hist_reg[1]) | (hist_reg[0] & comp_in) | (hist_reg[1] & comp_in);

	always_ff @(posedge aclk) begin
		if (!aresetn || reset_req) begin
			tq_cnt_reg <= 7'h00;
			seg_reg <= SEG_SYNC;
			q_cnt_reg <= 5'h00;
			ext_reg <= 3'h0;
			shr_reg <= 3'h0;
			resynced_reg <= 1'b0;
			comp_prev_reg <= 1'b1;
			hist_reg <= 2'b11;
			sampled_bit <= 1'b1;
			sample_strobe <= 1'b0;
			bit_start <= 1'b0;
		end else begin
			tq_cnt_reg <= tq_tick ? 7'h00 : tq_cnt_reg + 7'h01;
			comp_prev_reg <= comp_in;
			sample_strobe <= seg1_end;
			bit_start <= seg2_end;
			if (tq_tick) begin
				hist_reg <= {hist_reg[0], comp_in};
			end
			if (seg1_end) begin
				sampled_bit <= segments_reg.triple_sample_select ? maj : comp_in;
			end
			if (rx_edge && seg_reg == SEG_ONE) begin
				ext_reg <= phase_err;
				resynced_reg <= 1'b1;
			end else if (rx_edge && seg_reg == SEG_TWO) begin
				shr_reg <= sjw_len;
				resynced_reg <= 1'b1;
			end
			if (tq_tick) begin
				case (seg_reg)
					SEG_SYNC: begin
						seg_reg <= SEG_ONE;
						q_cnt_reg <= 5'h00;
					end
					SEG_ONE: begin
						seg_reg <= seg1_end ? SEG_TWO : SEG_ONE;
						q_cnt_reg <= seg1_end ? 5'h00 : q_next;
						if (seg1_end) begin
							ext_reg <= 3'h0;
						end
					end
					SEG_TWO: begin
						seg_reg <= seg2_end ? SEG_SYNC : SEG_TWO;
						q_cnt_reg <= seg2_end ? 5'h00 : q_next;
						if (seg2_end) begin
							shr_reg <= 3'h0;
							resynced_reg <= 1'b0;
						end
					end
					default: seg_reg <= SEG_SYNC;
				endcase
			end
		end
	end

	a_quantum_period: assert property (@(posedge aclk) disable iff (!aresetn || reset_req)
		(tq_tick && $stable(prescale_reg)) |=> !tq_tick && (tq_cnt_reg == 7'h00))
		else $error("Quantum counter did not restart after tick.");
	a_jump_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		ext_reg <= sjw_len && shr_reg <= sjw_len)
		else $error("Resync correction exceeds jump width.");
	a_single_sample: assert property (@(posedge aclk) disable iff (!aresetn || reset_req)
		(seg1_end && !segments_reg.triple_sample_select) |=> sampled_bit == $past(comp_in))
		else $error("Single sample does not match bus level.");

	// ----------------------------------------------------------------
	// Output stage.
	// ----------------------------------------------------------------
	logic bp_sel_reg;

	wire [1:0] out_mode = {output_reg.output_mode_hi, output_reg.output_mode_lo};
	wire tx_clock = (seg_reg == SEG_SYNC);
	wire cfo_drive_t norm_a = pin_drive(output_reg.pin_a, tx_bit);
	wire cfo_drive_t norm_b = pin_drive(output_reg.pin_b, tx_bit);
	wire cfo_drive_t clk_b = pin_drive(output_reg.pin_b, tx_clock);
	wire cfo_drive_t test_b = pin_drive(output_reg.pin_b, comp_in);
	wire cfo_drive_t rec_a = pin_drive(output_reg.pin_a, 1'b1);
	wire cfo_drive_t rec_b = pin_drive(output_reg.pin_b, 1'b1);
	logic [1:0] pin_out_next;
	logic [1:0] pin_oe_next;

	always_comb begin
		pin_out_next = {norm_b.out, norm_a.out};
		pin_oe_next = {norm_b.oe, norm_a.oe};
		if (reset_req) begin
			pin_oe_next = 2'b00;
		end else if (sleep_mode) begin
			pin_out_next = {rec_b.out, rec_a.out};
			pin_oe_next = {rec_b.oe, rec_a.oe};
		end else begin
			case (out_mode)
				MODE_NORMAL: pin_oe_next = {norm_b.oe, norm_a.oe};
				MODE_CLOCK: begin
					pin_out_next[1] = clk_b.out;
					pin_oe_next[1] = clk_b.oe;
				end
				MODE_TEST: begin
					pin_out_next[1] = test_b.out;
					pin_oe_next[1] = test_b.oe;
				end
				MODE_BIPHASE: begin
					pin_oe_next = tx_bit ? 2'b00 : {norm_b.oe & bp_sel_reg, norm_a.oe & !bp_sel_reg};
				end
				default: pin_oe_next = 2'b00;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || reset_req) begin
			bp_sel_reg <= 1'b0;
			serial_out_a <= 1'b0;
			serial_out_b <= 1'b0;
			serial_out_a_oe <= 1'b0;
			serial_out_b_oe <= 1'b0;
		end else begin
			if (seg2_end) begin
				bp_sel_reg <= bp_sel_reg ^ !tx_bit;
			end
			serial_out_a <= pin_out_next[0];
			serial_out_b <= pin_out_next[1];
			serial_out_a_oe <= pin_oe_next[0];
			serial_out_b_oe <= pin_oe_next[1];
		end
	end

	a_reset_float: assert property (@(posedge aclk) disable iff (!aresetn)
		reset_req [*2] |-> !serial_out_a_oe && !serial_out_b_oe)
		else $error("Outputs driven during reset request.");
	a_biphase_recessive: assert property (@(posedge aclk) disable iff (!aresetn)
		(!reset_req && !sleep_mode && out_mode == MODE_BIPHASE && tx_bit) |=> !serial_out_a_oe
		&& !serial_out_b_oe)
		else $error("Bi-phase recessive bit drives an output.");

endmodule

/* File: verif/cfo_bus_node.sv */
// Behavioural frame engine and bus node that feed the message port.
// Assumes the bench calls send only while no other message is under way.
`timescale 1ns/1ps
module cfo_bus_node(
	input wire logic aclk,
	input wire logic tx_bit,
	output logic msg_start,
	output logic [7:0] msg_id_high,
	output logic msg_byte_valid,
	output logic [7:0] msg_byte,
	output logic msg_done,
	output logic msg_abort,
	output logic comp_in
);
	// The wire level loops back; a dominant peer node wins on the wired line.
	logic peer_dom = 1'b0;
	assign comp_in = tx_bit & !peer_dom;
	initial begin
		{msg_start, msg_byte_valid, msg_done, msg_abort} = 4'h0;
		msg_id_high = 8'h00;
		msg_byte = 8'h00;
	end
	// Descriptor bytes first, then data; byte n carries id plus n; ab ends it by abort.
	task automatic send(input logic [7:0] id, input logic ab);
		@(posedge aclk);
		msg_start <= 1'b1;
		msg_id_high <= id;
		for (int n = 0; n < 10; n++) begin
			@(posedge aclk);
			msg_start <= 1'b0;
			msg_id_high <= ~id;
			msg_byte_valid <= 1'b1;
			msg_byte <= id + 8'(n);
		end
		@(posedge aclk);
		msg_byte_valid <= 1'b0;
		msg_byte <= ~msg_byte;
		msg_done <= !ab;
		msg_abort <= ab;
		@(posedge aclk);
		msg_done <= 1'b0;
		msg_abort <= 1'b0;
	endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the filter, timing and output block.
// Assumes the bus node model drives the message port and comparator.
`timescale 1ns/1ps
module testbench
	import cfo_pkg::*;
;
	logic aclk, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, tx_bit = 1, t;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, msg_id_high, msg_byte;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic msg_start, msg_byte_valid, msg_done, msg_abort, comp_in;
	logic sample_strobe, sampled_bit, bit_start;
	logic serial_out_a, serial_out_a_oe, serial_out_b, serial_out_b_oe;
	logic [7:0] cfg [5] = '{8'ha5, 8'h0f, 8'h01, 8'h12, 8'hda};
	logic [65:0] rq [$];
	logic [65:0] e;
	logic [1:0] wq [$];
	int error_cnt = 0, check_count = 0, seed = 25, cyc = 0;
	time t0;
	cfo_filter_timing cfo_filter_timing_i(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.msg_start, .msg_id_high, .msg_byte_valid, .msg_byte, .msg_done, .msg_abort,
		.tx_bit, .comp_in, .sample_strobe, .sampled_bit, .bit_start, .serial_out_a,
		.serial_out_a_oe, .serial_out_b, .serial_out_b_oe);
	cfo_bus_node cfo_bus_node_i(.aclk, .tx_bit, .msg_start, .msg_id_high, .msg_byte_valid,
		.msg_byte, .msg_done, .msg_abort, .comp_in);
	initial begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic check(input logic [31:0] seen, exp, input string nm);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	// --------------------------------------------------------------
	// Bus cycles and the response monitor.
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready)
			check({30'h0, s_axi_bresp}, {30'h0, wq.pop_front()}, "bresp");
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			check({30'h0, s_axi_rresp}, {30'h0, e[1:0]}, "rresp");
			check(s_axi_rdata & e[65:34], e[33:2], "rdata");
		end
	end
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
		logic ad = 0;
		logic wd = 0;
		wq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= {3'($random(seed)), 1'b1};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (!ad && s_axi_awready) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(ad && wd));
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] idx, input logic [31:0] m, d, input logic [1:0] r);
		rq.push_back({m, d & m, r});
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	task automatic pins(input logic [3:0] x, input string nm);
		repeat (3) @(posedge aclk);
		check({28'h0, serial_out_a & serial_out_a_oe, serial_out_a_oe,
			serial_out_b & serial_out_b_oe, serial_out_b_oe}, {28'h0, x}, nm);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		pins(4'h0, "reset pins");
		rd(IDX_CONTROL, 32'hff, {24'h0, RST_CONTROL}, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			rd(6'(4 + i), 32'hff, {24'h0, RST_CONFIG}, RESP_OKAY);
			wr(6'(4 + i), cfg[i], RESP_OKAY);
			rd(6'(4 + i), 32'hff, {24'h0, cfg[i]}, RESP_OKAY);
		end
		rd(6'h3f, 32'hffffffff, 32'h0, RESP_DECERR);
		wr(IDX_CONTROL, 8'h04, RESP_OKAY);
		wr(IDX_FILTER_CODE, 8'h00, RESP_SLVERR);
		rd(IDX_FILTER_CODE, 32'hffffffff, 32'h0, RESP_SLVERR);
		$display("test registers done");
		@(posedge aclk iff bit_start === 1'b1);
		t0 = $time;
		@(posedge aclk iff bit_start === 1'b1);
		check(32'(($time - t0) / 5), 32'd24, "bit length");
		@(posedge aclk iff sample_strobe === 1'b1);
		check(32'(($time - t0) / 5), 32'd40, "sample point");
		for (int i = 0; i < 8; i++) begin
			t = 1'($random(seed));
			tx_bit <= t;
			pins({t, 1'b1, t, 1'b1}, "normal pins");
		end
		wr(IDX_CONTROL, 8'h06, RESP_OKAY);
		tx_bit <= 1'b0;
		pins(4'hf, "sleep pins");
		wr(IDX_CONTROL, 8'h05, RESP_OKAY);
		wr(IDX_OUTPUT_CTRL, 8'hd8, RESP_OKAY);
		tx_bit <= 1'b1;
		wr(IDX_CONTROL, 8'h04, RESP_OKAY);
		pins(4'h0, "biphase recessive");
		@(posedge aclk iff bit_start === 1'b1);
		tx_bit <= 1'b0;
		pins(4'h4, "biphase first");
		@(posedge aclk iff bit_start === 1'b1);
		pins(4'h1, "biphase second");
		tx_bit <= 1'b1;
		wr(IDX_CONTROL, 8'h05, RESP_OKAY);
		wr(IDX_OUTPUT_CTRL, 8'hdb, RESP_OKAY);
		wr(IDX_CONTROL, 8'h04, RESP_OKAY);
		@(posedge aclk iff bit_start === 1'b1);
		pins(4'hf, "clock high");
		pins(4'hd, "clock low");
		wr(IDX_CONTROL, 8'h05, RESP_OKAY);
		wr(IDX_OUTPUT_CTRL, 8'hd9, RESP_OKAY);
		wr(IDX_CONTROL, 8'h04, RESP_OKAY);
		cfo_bus_node_i.peer_dom <= 1'b1;
		pins(4'hd, "test pins");
		repeat (2) @(posedge aclk iff bit_start === 1'b1);
		rd(IDX_STATUS, 32'h08, 32'h0, RESP_OKAY);
		cfo_bus_node_i.peer_dom <= 1'b0;
		repeat (2) @(posedge aclk iff bit_start === 1'b1);
		rd(IDX_STATUS, 32'h08, 32'h08, RESP_OKAY);
		$display("test timing and pins done");
		cfo_bus_node_i.send(8'h55, 1'b0);
		rd(IDX_STATUS, 32'h07, 32'h0, RESP_OKAY);
		cfo_bus_node_i.send(8'ha3, 1'b0);
		rd(IDX_STATUS, 32'h07, 32'h05, RESP_OKAY);
		for (int n = 0; n < RXBUF_BYTES; n++)
			rd(6'(IDX_RXBUF_BASE + n), 32'hff, 32'(8'ha3 + n), RESP_OKAY);
		cfo_bus_node_i.send(8'hac, 1'b0);
		cfo_bus_node_i.send(8'ha0, 1'b0);
		rd(IDX_STATUS, 32'h07, 32'h07, RESP_OKAY);
		wr(IDX_COMMAND, 8'h03, RESP_OKAY);
		rd(IDX_STATUS, 32'h03, 32'h01, RESP_OKAY);
		rd(IDX_RXBUF_BASE, 32'hff, 32'hac, RESP_OKAY);
		wr(IDX_COMMAND, 8'h01, RESP_OKAY);
		rd(IDX_STATUS, 32'h01, 32'h0, RESP_OKAY);
		cfo_bus_node_i.send(8'ha1, 1'b1);
		rd(IDX_STATUS, 32'h03, 32'h0, RESP_OKAY);
		$display("test messages done");
		final_report();
	end
endmodule
